// [rtl/sbp_pkg.sv]
// Constants and types for the static branch predictor.
// Assumes one core clock domain shared with decoder and target buffer.
// Function
// - Static scheme used only when the target buffer holds no history.
// - Without history, unconditional branches predict taken.
// - Without history, backward conditional branches predict taken.
// - Without history, forward conditional branches predict not taken.
// - Without history, indirect branches predict not taken.
// - Prefix byte 3E hints taken, prefix byte 2E hints not taken.
// - Hints honoured only on relative conditional branches, ignored else.
// - With no target buffer prediction, a valid hint replaces static.
// - Hints consulted only while building a trace, never afterwards.
// - Never-taken conditional branches get no target buffer entry.
// - Spin-wait hint is architecturally a no-op marking a polling loop.
// - Conditional move writes source only when equal flag set.
// - Set-on-condition writes one if condition holds, else zero.
package sbp_pkg;

    typedef enum logic [1:0] {
        SBP_BR_UNCOND,
        SBP_BR_COND_REL,
        SBP_BR_INDIRECT,
        SBP_BR_OTHER
    } sbp_br_kind_t;

    localparam logic [7:0] SBP_HINT_TAKEN = 8'h3E;
    localparam logic [7:0] SBP_HINT_NOT_TAKEN = 8'h2E;
    localparam logic SBP_RESET_BIT = 1'b0;
    localparam logic [7:0] SBP_SET_TRUE = 8'h01;
    localparam logic [7:0] SBP_SET_FALSE = 8'h00;
    localparam int SBP_SPIN_CNT_W = 4;

endpackage : sbp_pkg

// [rtl/sbp_top.sv]
// Static branch predictor with spin-wait tracking and flag-based selects.
// Assumes decoder, trace builder and target buffer share core_clk_i.
`timescale 1ns/1ns
module sbp_top
    import sbp_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Branch lookup from decoder
    input wire logic br_valid_i,
    input wire sbp_br_kind_t br_kind_i,
    input wire logic [ADDR_W-1:0] br_pc_i,
    input wire logic [ADDR_W-1:0] br_target_i,
    input wire logic br_prefix_valid_i,
    input wire logic [7:0] br_prefix_i,
    input wire logic trace_build_i,
    // Target buffer lookup result
    input wire logic btb_hit_i,
    input wire logic btb_taken_i,
    // Branch resolution
    input wire logic res_valid_i,
    input wire logic res_cond_i,
    input wire logic res_taken_i,
    // Spin-wait hint
    input wire logic spin_hint_i,
    input wire logic spin_exit_i,
    // Conditional move and set-on-condition
    input wire logic op_valid_i,
    input wire logic op_is_cmov_i,
    input wire logic flag_eq_i,
    input wire logic cond_i,
    input wire logic [DATA_W-1:0] cmov_src_i,
    input wire logic [DATA_W-1:0] cmov_dst_i,
    // Prediction out
    output logic pred_valid_o,
    output logic pred_taken_o,
    output logic pred_static_o,
    // Target buffer allocation
    output logic btb_alloc_o,
    // Polling loop marker
    output logic spin_loop_o,
    output logic order_relax_o,
    // Operation result
    output logic res_wr_o,
    output logic [DATA_W-1:0] res_data_o
);

    wire backward = br_target_i < br_pc_i;
    wire hint_t = br_prefix_valid_i && br_prefix_i == SBP_HINT_TAKEN;
    wire hint_n = br_prefix_valid_i
        && br_prefix_i == SBP_HINT_NOT_TAKEN;
    wire hint_ok = trace_build_i && br_kind_i == SBP_BR_COND_REL
        && (hint_t || hint_n);
    logic static_dir;
    always_comb begin
        unique case (br_kind_i)
            SBP_BR_UNCOND: static_dir = 1'b1;
            SBP_BR_COND_REL: static_dir = backward;
            SBP_BR_INDIRECT: static_dir = 1'b0;
            SBP_BR_OTHER: static_dir = 1'b0;
        endcase
    end
    wire nohist_dir = hint_ok ? hint_t : static_dir;
    wire pred_dir_d = btb_hit_i ? btb_taken_i : nohist_dir;
    wire alloc_d = res_valid_i && !(res_cond_i && !res_taken_i);
    wire [DATA_W-1:0] cmov_val = flag_eq_i ? cmov_src_i
        : cmov_dst_i;
    wire [DATA_W-1:0] set_val = {{(DATA_W-8){1'b0}},
        (cond_i ? SBP_SET_TRUE : SBP_SET_FALSE)};
    wire [DATA_W-1:0] op_val = op_is_cmov_i ? cmov_val : set_val;

    wire [DATA_W-1:0] res_data_d = op_valid_i ? op_val : res_data_o;

    logic spin_q;
    logic spin_d;
    // Spin hint only marks a loop; no architectural state changes
    // Hint wins over an exit in the same cycle
    assign spin_d = spin_hint_i ? 1'b1
        : (spin_exit_i ? 1'b0 : spin_q);
    // Exit of a marked loop relaxes the order check for one cycle
    wire relax_d = spin_q && spin_exit_i;

    // Prediction for the lookup of the previous cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pred_valid_o <= SBP_RESET_BIT;
            pred_taken_o <= SBP_RESET_BIT;
            pred_static_o <= SBP_RESET_BIT;
        end else begin
            pred_valid_o <= br_valid_i;
            pred_taken_o <= br_valid_i && pred_dir_d;
            pred_static_o <= br_valid_i && !btb_hit_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            btb_alloc_o <= SBP_RESET_BIT;
        end else begin
            btb_alloc_o <= alloc_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            spin_q <= SBP_RESET_BIT;
            order_relax_o <= SBP_RESET_BIT;
        end else begin
            spin_q <= spin_d;
            order_relax_o <= relax_d;
        end
    end

    // Result register keeps its value between operations
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            res_wr_o <= SBP_RESET_BIT;
            res_data_o <= '0;
        end else begin
            res_wr_o <= op_valid_i;
            res_data_o <= res_data_d;
        end
    end

    assign spin_loop_o = spin_q;

    // Lookup answered by the static or hint path
    sequence s_nohist;
        br_valid_i && !btb_hit_i;
    endsequence

    sequence s_cond_static;
        br_valid_i && !btb_hit_i && br_kind_i == SBP_BR_COND_REL && !hint_ok;
    endsequence

    sequence s_hinted;
        br_valid_i && !btb_hit_i && trace_build_i
            && br_kind_i == SBP_BR_COND_REL && br_prefix_valid_i;
    endsequence

    // Polling loop marked, then left without a new hint
    sequence s_spin_exit;
        spin_hint_i ##1 (!spin_hint_i && spin_exit_i);
    endsequence

    AST_BTB_FIRST: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        br_valid_i && btb_hit_i |=> pred_taken_o == $past(btb_taken_i))
        else $error("btb prediction not used");

    AST_STATIC_SRC: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        br_valid_i |=> pred_valid_o && pred_static_o == !$past(btb_hit_i))
        else $error("prediction source wrong");

    AST_UNCOND: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_nohist ##0 (br_kind_i == SBP_BR_UNCOND)
        |=> pred_taken_o && pred_static_o)
        else $error("unconditional not taken");

    AST_BACK: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_cond_static ##0 backward |=> pred_taken_o)
        else $error("backward not taken");

    AST_FWD: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_cond_static ##0 !backward |=> !pred_taken_o)
        else $error("forward taken");

    AST_INDIR: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_nohist ##0 (br_kind_i == SBP_BR_INDIRECT) |=> !pred_taken_o)
        else $error("indirect taken");

    AST_OTHER: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_nohist ##0 (br_kind_i == SBP_BR_OTHER) |=> !pred_taken_o)
        else $error("other branch kind taken");

    AST_HINT: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_hinted ##0 (br_prefix_i == SBP_HINT_NOT_TAKEN) |=> !pred_taken_o)
        else $error("not-taken hint ignored");

    AST_HINT_TAKEN: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_hinted ##0 (br_prefix_i == SBP_HINT_TAKEN) |=> pred_taken_o)
        else $error("taken hint ignored");

    AST_NOHINT_BUILT: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_nohist ##0 (!trace_build_i && br_kind_i == SBP_BR_COND_REL)
        |=> pred_taken_o == $past(backward))
        else $error("hint used outside trace build");

    AST_NO_ALLOC: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        res_valid_i && res_cond_i && !res_taken_i |=> !btb_alloc_o)
        else $error("never-taken branch allocated");

    AST_ALLOC: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        res_valid_i && !(res_cond_i && !res_taken_i) |=> btb_alloc_o)
        else $error("taken branch not allocated");

    AST_CMOV: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        op_valid_i && op_is_cmov_i |=> res_data_o
            == ($past(flag_eq_i) ? $past(cmov_src_i) : $past(cmov_dst_i)))
        else $error("cmov wrong value");

    AST_RES_HOLD: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        !op_valid_i |=> !res_wr_o && res_data_o == $past(res_data_o))
        else $error("result changed without operation");

    AST_SETCC: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        op_valid_i && !op_is_cmov_i
        |=> res_data_o == DATA_W'($past(cond_i)))
        else $error("set-on-condition wrong value");

    AST_SPIN: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        spin_hint_i |=> spin_loop_o)
        else $error("spin loop not marked");

    AST_RELAX: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_spin_exit |=> order_relax_o && !spin_loop_o)
        else $error("loop exit not relaxed");

endmodule : sbp_top

// [dv/sbp_btb_model.sv]
// Target buffer model: one history entry seen by the predictor.
// Assumes the bench presets or clears the entry between lookups.
`timescale 1ns/1ns
module sbp_btb_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Allocation and preset
    input wire logic alloc_i,
    input wire logic alloc_taken_i,
    input wire logic load_i,
    input wire logic load_taken_i,
    input wire logic clear_i,
    // Lookup result
    output logic hit_o,
    output logic taken_o
);
    logic valid_q;
    logic dir_q;
    always @(posedge core_clk_i) begin
        if (reset_i || clear_i) valid_q <= 1'b0;
        else if (alloc_i || load_i) valid_q <= 1'b1;
        if (alloc_i || load_i) dir_q <= load_i ? load_taken_i : alloc_taken_i;
    end
    assign hit_o = valid_q;
    // Direction is the inverted stored bit while no history
    assign taken_o = valid_q ? dir_q : !dir_q;
endmodule : sbp_btb_model

// [dv/static_branch_predictor_tb.sv]
// Self-checking bench for the static branch predictor.
// Assumes fixed one-cycle answers as described in the hand-over.
`timescale 1ns/1ns
module static_branch_predictor_tb import sbp_pkg::*; ;
    sbp_br_kind_t br_kind_i;
    logic [31:0] br_pc_i, br_target_i, cmov_src_i, cmov_dst_i, res_data_o;
    logic [7:0] br_prefix_i;
    logic core_clk_i, reset_i, br_valid_i, br_prefix_valid_i, trace_build_i;
    logic btb_hit_i, btb_taken_i, res_valid_i, res_cond_i, res_taken_i;
    logic spin_hint_i, spin_exit_i, op_valid_i, op_is_cmov_i, flag_eq_i;
    logic cond_i, pred_valid_o, pred_taken_o, pred_static_o, btb_alloc_o;
    logic spin_loop_o, order_relax_o, res_wr_o, load_i, load_taken_i, clear_i;
    int error_cnt, total_checks;
    // Kind, back, prefix, 3E, build, hit, hit dir, exp taken, exp static
    logic [9:0] rows [13] = '{10'b00_0001_0011, 10'b01_1001_0011,
        10'b01_0001_0001, 10'b10_1001_0001, 10'b01_0111_0011,
        10'b01_1101_0001, 10'b01_1100_0011, 10'b00_0101_0011,
        10'b10_1111_0001, 10'b01_1101_1000, 10'b01_0111_1110,
        10'b11_0111_0001, 10'b00_0001_1000};
    sbp_top #(.ADDR_W(32), .DATA_W(32)) u_dut (.core_clk_i, .reset_i,
        .br_valid_i, .br_kind_i, .br_pc_i, .br_target_i, .br_prefix_valid_i,
        .br_prefix_i, .trace_build_i, .btb_hit_i, .btb_taken_i, .res_valid_i,
        .res_cond_i, .res_taken_i, .spin_hint_i, .spin_exit_i, .op_valid_i,
        .op_is_cmov_i, .flag_eq_i, .cond_i, .cmov_src_i, .cmov_dst_i,
        .pred_valid_o, .pred_taken_o, .pred_static_o, .btb_alloc_o,
        .spin_loop_o, .order_relax_o, .res_wr_o, .res_data_o);
    sbp_btb_model u_btb (.core_clk_i, .reset_i, .alloc_i(btb_alloc_o),
        .alloc_taken_i(res_taken_i), .load_i, .load_taken_i, .clear_i,
        .hit_o(btb_hit_i), .taken_o(btb_taken_i));
    task automatic step;
        @(posedge core_clk_i);
        #1;
    endtask : step
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        core_clk_i = 0;
        forever #25 core_clk_i = !core_clk_i;
    end
    initial begin
        #1_000_000;
        error_cnt++;
        summarize;
    end
    initial begin
        {br_valid_i, br_prefix_valid_i, trace_build_i, res_valid_i} = 0;
        {res_cond_i, res_taken_i, spin_hint_i, spin_exit_i, op_valid_i} = 0;
        {op_is_cmov_i, flag_eq_i, cond_i, load_i, load_taken_i, clear_i} = 0;
        {br_pc_i, br_target_i, cmov_src_i, cmov_dst_i, br_prefix_i} = 0;
        br_kind_i = SBP_BR_UNCOND;
        reset_i = 1;
        repeat (8) step;
        chk("reset", 0, {pred_valid_o, btb_alloc_o, spin_loop_o, res_wr_o});
        reset_i = 0;
        foreach (rows[i]) begin
            {load_i, load_taken_i, clear_i} = {rows[i][3:2], !rows[i][3]};
            step;
            {load_i, clear_i} = 2'b00;
            br_kind_i = sbp_br_kind_t'(rows[i][9:8]);
            br_pc_i = 32'h0000_1000;
            br_target_i = rows[i][7] ? 32'h0000_0FFF : 32'h0000_1004;
            br_prefix_valid_i = rows[i][6];
            br_prefix_i = rows[i][5] ? SBP_HINT_TAKEN : SBP_HINT_NOT_TAKEN;
            {trace_build_i, br_valid_i} = {rows[i][4], 1'b1};
            step;
            br_valid_i = 0;
            chk("pred", {1'b1, rows[i][1:0]},
                {pred_valid_o, pred_taken_o, pred_static_o});
            chk("pred_dir", rows[i][1], pred_taken_o);
            chk("pred_src", rows[i][0], pred_static_o);
            chk("pred_hint", rows[i][1:0],
                {pred_taken_o, pred_static_o});
        end
        {res_valid_i, res_cond_i, res_taken_i} = 3'b110;
        step;
        chk("alloc_nt", 0, btb_alloc_o);
        {res_valid_i, res_cond_i, res_taken_i} = 3'b111;
        step;
        {res_valid_i, res_cond_i, res_taken_i} = 3'b000;
        chk("alloc_t", 1, btb_alloc_o);
        spin_hint_i = 1;
        step;
        {spin_hint_i, spin_exit_i} = 2'b01;
        chk("spin", 1, spin_loop_o);
        step;
        spin_exit_i = 0;
        chk("relax", 1, order_relax_o);
        step;
        chk("spin_end", 0, {spin_loop_o, order_relax_o});
        {cmov_src_i, cmov_dst_i} = {32'hA5A5_0001, 32'h5A5A_0002};
        for (int j = 0; j < 4; j++) begin
            {op_is_cmov_i, flag_eq_i} = {j[1], j[0]};
            {cond_i, op_valid_i} = {!j[0], 1'b1};
            step;
            op_valid_i = 0;
            chk("res", j[1] ? (j[0] ? cmov_src_i : cmov_dst_i) : {31'h0, !j[0]},
                res_data_o);
            chk("res_wr", 1, res_wr_o);
        end
        {spin_hint_i, br_valid_i} = 2'b11;
        step;
        {spin_hint_i, br_valid_i} = 2'b00;
        chk("spin_pre", 1, spin_loop_o);
        reset_i = 1;
        step;
        reset_i = 0;
        chk("reset_mid", 0, {pred_valid_o, btb_alloc_o, spin_loop_o, res_wr_o});
        chk("reset_data", 0, res_data_o);
        summarize;
    end
endmodule : static_branch_predictor_tb
